// ==== logic/codec_offset_flag_filter_regs.sv ====
`timescale 1ns/1ps
// Contract
// - The offset code sets the data start point in bit clocks after frame start, 0 to 255.
// - In DSP format the offset is counted from the rising edge of the word clock.
// - Four read-only overflow flags sit at bits 7 to 4 and are zero after reset.
// - An overflow flag stays set after the overflow condition goes away.
// - Reading the flag register clears the flags it returns, but an overflow in the same cycle sets its flag again.
// - PLL R codes 1 to 15 select that value, code 0 selects 16, reset value is 1.
// - Left ADC highpass code 00 disables it, other codes pick the corner ratio.
// - Right ADC highpass uses the same encoding in bits 5 to 4.
// - Bits 3 and 1 enable the left and right DAC effects filters.
// - Bits 2 and 0 enable the left and right DAC de-emphasis filters.
// - The two-bit transfer mode selects I2S, DSP, right- or left-justified format.
// - With bit clock output and the rate bit set, a frame has 256 bit clocks.
module codec_offset_flag_filter_regs
  import codec_regs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire reg_req_t   req,
  input  wire ovf_t       overflow,
  input  wire xfer_mode_t xfer_mode,
  input  wire logic       bclk_is_output,
  input  wire logic       rate_256,
  output logic [7:0]      rdata,
  output logic [7:0]      data_offset,
  output logic            offset_from_wclk_rise,
  output logic [8:0]      bclks_per_frame,
  output logic            offset_in_range,
  output logic [4:0]      pll_r_divider,
  output filter_t         filter_ctl,
  output logic            hpf_left_en,
  output logic            hpf_right_en
);

  state_t state;
  state_t next_state;

  function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
    unique case (a)
      offset_addr: read_mux = s.offset;
      flags_addr:  read_mux = {s.flags, s.pll_r};
      filter_addr: read_mux = s.filter;
      default:     read_mux = '0;
    endcase
  endfunction

  logic       clear_rd;
  logic       mode_256;
  logic [7:0] max_offset;

  assign clear_rd = req.rd && (req.addr == flags_addr);

  always_comb begin
    next_state = state;
    next_state.rdata = req.rd ? read_mux(state, req.addr) : state.rdata;
    if (clear_rd) begin
      next_state.flags = '0;
    end
    next_state.flags = next_state.flags | overflow;
    if (req.wr) begin
      unique case (req.addr)
        offset_addr: next_state.offset = req.wdata;
        flags_addr:  next_state.pll_r = 4'(req.wdata);
        filter_addr: next_state.filter = filter_t'(req.wdata);
        default:     next_state.offset = state.offset;
      endcase
    end
    if (srst) begin
      next_state.offset = offset_reset;
      next_state.flags  = '0;
      next_state.pll_r  = pll_r_reset;
      next_state.filter = filter_t'(filter_reset);
      next_state.rdata  = '0;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  assign rdata       = state.rdata;
  assign data_offset = state.offset;
  assign filter_ctl  = state.filter;
  assign hpf_left_en  = (state.filter.hpf_left != hpf_off);
  assign hpf_right_en = (state.filter.hpf_right != hpf_off);
  assign pll_r_divider = (state.pll_r == '0) ? pll_r_zero_value : {1'b0, state.pll_r};
  assign offset_from_wclk_rise = (xfer_mode == fmt_dsp);
  assign mode_256 = bclk_is_output && rate_256;
  assign bclks_per_frame = mode_256 ? frame_256_clocks : '0;

  always_comb begin
    if (mode_256) begin
      max_offset = (xfer_mode == fmt_dsp) ? max_256_dsp : max_256_std;
    end else begin
      max_offset = (xfer_mode == fmt_dsp) ? max_cont_dsp : max_cont_std;
    end
  end
  assign offset_in_range = (state.offset <= max_offset);

  a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
    (|overflow) |=> ((state.flags & $past(overflow)) == $past(overflow)))
    else $error("overflow flag not set");

  a_flag_read_clear: assert property (@(posedge clock) disable iff (srst)
    (clear_rd && overflow == '0) |=> (state.flags == '0))
    else $error("flags not cleared by read");

  a_flag_hold: assert property (@(posedge clock) disable iff (srst)
    (!clear_rd) |=> ((state.flags & $past(state.flags)) == $past(state.flags)))
    else $error("flag lost without read");

  a_flag_read_data: assert property (@(posedge clock) disable iff (srst)
    (clear_rd) |=> (rdata[7:4] == $past(state.flags)))
    else $error("flag read data wrong");

  a_pll_write: assert property (@(posedge clock) disable iff (srst)
    (req.wr && req.addr == flags_addr && !clear_rd && overflow == '0)
      |=> (state.pll_r == $past(req.wdata[3:0]) && state.flags == $past(state.flags)))
    else $error("pll write handling wrong");

  a_pll_decode: assert property (@(posedge clock) disable iff (srst)
    (state.pll_r == 4'h0) |-> (pll_r_divider == 5'h10))
    else $error("pll zero decode wrong");

  a_offset_write: assert property (@(posedge clock) disable iff (srst)
    (req.wr && req.addr == offset_addr) |=> (data_offset == $past(req.wdata)))
    else $error("offset write lost");

  a_filter_write: assert property (@(posedge clock) disable iff (srst)
    (req.wr && req.addr == filter_addr) |=> (filter_ctl == $past(req.wdata)))
    else $error("filter write lost");

  a_reset_values: assert property (@(posedge clock)
    srst |=> (state.flags == '0 && state.pll_r == 4'h1 && data_offset == 8'h00))
    else $error("reset values wrong");

  a_frame_256: assert property (@(posedge clock) disable iff (srst)
    (bclk_is_output && rate_256) |-> (bclks_per_frame == 9'h100))
    else $error("frame length wrong");

  a_flag_set_wins: assert property (@(posedge clock) disable iff (srst)
    (clear_rd && overflow != '0) |=> (state.flags == $past(overflow)))
    else $error("event lost on clearing read");

  a_read_offset: assert property (@(posedge clock) disable iff (srst)
    (req.rd && req.addr == offset_addr) |=> (rdata == $past(state.offset)))
    else $error("offset read data wrong");

  a_read_pll: assert property (@(posedge clock) disable iff (srst)
    clear_rd |=> (rdata[3:0] == $past(state.pll_r)))
    else $error("pll read data wrong");

  a_read_filter: assert property (@(posedge clock) disable iff (srst)
    (req.rd && req.addr == filter_addr) |=> (rdata == $past(state.filter)))
    else $error("filter read data wrong");

  a_offset_hold: assert property (@(posedge clock) disable iff (srst)
    !(req.wr && req.addr == offset_addr) |=> $stable(data_offset))
    else $error("offset changed without write");

  a_filter_hold: assert property (@(posedge clock) disable iff (srst)
    !(req.wr && req.addr == filter_addr) |=> $stable(filter_ctl))
    else $error("filter changed without write");

  a_hpf_left_off: assert property (@(posedge clock) disable iff (srst)
    (filter_ctl.hpf_left == hpf_off) |-> !hpf_left_en)
    else $error("left highpass not disabled");

  a_hpf_left_on: assert property (@(posedge clock) disable iff (srst)
    (filter_ctl.hpf_left != hpf_off) |-> hpf_left_en)
    else $error("left highpass not enabled");

  a_hpf_right_off: assert property (@(posedge clock) disable iff (srst)
    (filter_ctl.hpf_right == hpf_off) |-> !hpf_right_en)
    else $error("right highpass not disabled");

  a_hpf_right_on: assert property (@(posedge clock) disable iff (srst)
    (filter_ctl.hpf_right != hpf_off) |-> hpf_right_en)
    else $error("right highpass not enabled");

  a_dsp_reference: assert property (@(posedge clock) disable iff (srst)
    (xfer_mode == fmt_dsp) |-> offset_from_wclk_rise)
    else $error("dsp offset reference wrong");

  a_mode_reference: assert property (@(posedge clock) disable iff (srst)
    (xfer_mode != fmt_dsp) |-> !offset_from_wclk_rise)
    else $error("non dsp offset reference wrong");

  a_frame_cont: assert property (@(posedge clock) disable iff (srst)
    !(bclk_is_output && rate_256) |-> (bclks_per_frame == '0))
    else $error("continuous frame length wrong");

  a_limit_cont_dsp: assert property (@(posedge clock) disable iff (srst)
    (!(bclk_is_output && rate_256) && xfer_mode == fmt_dsp)
      |-> (offset_in_range == (data_offset <= max_cont_dsp)))
    else $error("continuous dsp limit wrong");

  a_limit_256_std: assert property (@(posedge clock) disable iff (srst)
    ((bclk_is_output && rate_256) && xfer_mode != fmt_dsp)
      |-> (offset_in_range == (data_offset <= max_256_std)))
    else $error("256 clock limit wrong");

  a_pll_nonzero: assert property (@(posedge clock) disable iff (srst)
    (state.pll_r != '0) |-> (pll_r_divider == 5'(state.pll_r)))
    else $error("pll nonzero decode wrong");

endmodule // codec_offset_flag_filter_regs

// ==== shared/codec_regs_pkg.sv ====
package codec_regs_pkg;

  localparam logic [7:0] offset_addr      = 8'h0a;
  localparam logic [7:0] flags_addr       = 8'h0b;
  localparam logic [7:0] filter_addr      = 8'h0c;
  localparam logic [7:0] offset_reset     = 8'h00;
  localparam logic [3:0] pll_r_reset      = 4'h1;
  localparam logic [7:0] filter_reset     = 8'h00;
  localparam logic [4:0] pll_r_zero_value = 5'h10;
  localparam logic [8:0] frame_256_clocks = 9'h100;

  // Offset limits per bit clock mode and format
  localparam logic [7:0] max_cont_std = 8'h11;
  localparam logic [7:0] max_cont_dsp = 8'h10;
  localparam logic [7:0] max_256_std  = 8'hf2;
  localparam logic [7:0] max_256_dsp  = 8'hf1;

  typedef enum logic [1:0] {
    fmt_i2s                   = 2'h0,
    fmt_dsp                   = 2'h1,
    right_justified_format    = 2'h2,
    left_justified_format     = 2'h3
  } xfer_mode_t;

  typedef enum logic [1:0] {
    hpf_off  = 2'h0,
    hpf_0045 = 2'h1,
    hpf_0125 = 2'h2,
    hpf_025  = 2'h3
  } hpf_mode_t;

  typedef struct packed {
    logic       adc_left;
    logic       adc_right;
    logic       dac_left;
    logic       dac_right;
  } ovf_t;

  typedef struct packed {
    hpf_mode_t  hpf_left;
    hpf_mode_t  hpf_right;
    logic       fx_left;
    logic       deemph_left;
    logic       fx_right;
    logic       deemph_right;
  } filter_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] offset;
    ovf_t       flags;
    logic [3:0] pll_r;
    filter_t    filter;
    logic [7:0] rdata;
  } state_t;

endpackage

// ==== sim/codec_offset_flag_filter_regs_bench.sv ====
`timescale 1ns/1ps
module codec_offset_flag_filter_regs_bench;
  import codec_regs_pkg::*;
  logic       clock, srst, bclk_is_output, rate_256, from_rise, in_range, hl, hr;
  reg_req_t   req;
  ovf_t       overflow;
  xfer_mode_t xfer_mode;
  logic [7:0] rdata, data_offset, lim;
  logic [8:0] bclks;
  logic [4:0] pll_div;
  filter_t    filter_ctl;
  int         n_fail, samples_checked;

  codec_offset_flag_filter_regs codec_offset_flag_filter_regs_i (
    .clock(clock), .srst(srst), .req(req), .overflow(overflow), .xfer_mode(xfer_mode),
    .bclk_is_output(bclk_is_output), .rate_256(rate_256), .rdata(rdata),
    .data_offset(data_offset), .offset_from_wclk_rise(from_rise), .bclks_per_frame(bclks),
    .offset_in_range(in_range), .pll_r_divider(pll_div), .filter_ctl(filter_ctl),
    .hpf_left_en(hl), .hpf_right_en(hr));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock) #1 req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input ovf_t ev = 4'h0);
    @(posedge clock) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    overflow = ev;
    @(posedge clock) #1 req.rd = 1'b0;
    overflow = 4'h0;
    chk(9'(rdata), 9'(e));
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    req = '0;
    overflow = 4'h0;
    xfer_mode = fmt_i2s;
    bclk_is_output = 1'b1;
    rate_256 = 1'b0;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h01);
    rd(8'h0c, 8'h00);
    chk(9'(pll_div), 9'h001);
    wr(8'h0a, 8'hff);
    chk(9'(data_offset), 9'h0ff);
    wr(8'h0d, 8'h5a);
    rd(8'h0d, 8'h00);
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        xfer_mode = xfer_mode_t'(m);
        rate_256 = r[0];
        lim = r ? (m == 1 ? 8'hf1 : 8'hf2) : (m == 1 ? 8'h10 : 8'h11);
        wr(8'h0a, lim);
        chk(9'(in_range), 9'h001);
        wr(8'h0a, lim + 8'h01);
        chk(9'(in_range), 9'h000);
        chk(bclks, r ? 9'h100 : 9'h000);
        chk(9'(from_rise), 9'(m == 1));
      end
    end
    bclk_is_output = 1'b0;
    #1 chk(bclks, 9'h000);
    for (int c = 0; c < 16; c++) begin
      wr(8'h0b, 8'hf0 | 8'(c));
      chk(9'(pll_div), c == 0 ? 9'h010 : 9'(c));
      rd(8'h0b, 8'(c));
    end
    @(posedge clock) #1 overflow = 4'b1010;
    @(posedge clock) #1 overflow = 4'h0;
    repeat (3) @(posedge clock);
    rd(8'h0b, 8'haf, 4'b0001);
    rd(8'h0b, 8'h1f);
    rd(8'h0b, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0c, {2'(c), 2'(3 - c), 4'(1 << c)});
      chk(9'(filter_ctl), 9'({2'(c), 2'(3 - c), 4'(1 << c)}));
      chk(9'({hl, hr}), 9'({c != 0, c != 3}));
      rd(8'h0c, {2'(c), 2'(3 - c), 4'(1 << c)});
    end
    // Mid-run reset after every register holds a non-reset value
    rd(8'h0b, 8'h0f, 4'hf);
    @(posedge clock) #1 srst = 1'b1;
    @(posedge clock) #1 srst = 1'b0;
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h01);
    rd(8'h0c, 8'h00);
    chk(9'(pll_div), 9'h001);
    conclude();
  end
endmodule // codec_offset_flag_filter_regs_bench
